// ---- eipc_pkg.sv ----
// constants and field layout of the external interrupt and priority block
// Operation
// (RL1) ext2 pending flag cleared when service begins, and by processor write.
// (RL2) ext2 pending flag set on configured trigger, or by processor write.
// (RL3) ext2 type 0: level trigger, low active, high when polarity bit set.
// (RL4) ext2 type 1: edge trigger, falling, rising when polarity bit set.
// (RL5) low basic priority register at 0xB8, bits 6..0 per basic source.
// (RL6) high basic priority register at 0xB7, same bit order.
// (RL7) extended enable register at 0xAD; bit 4 reserved.
// (RL8) system flag request: OR of flags, each gated by its own enable; the bus start and stop detect flags share enable bit 7.
// (RL9) keypad, ADC, SPI requests need flag and matching extended enable.
// (RL10) extended low priority register at 0xAE, same order as enables.
// (RL11) extended high priority register at 0xAF, same order.
// (RL12) software writes zero to reserved bits of these registers.
// (RL13) ext1 pin from 3-bit select; low bits in page-0 config bits 7:6.
// (RL14) ext0 pin from 3-bit select; low bits in page-0 config bits 5:4.
// (RL15) ext2 filter mode: off, 3 clock samples, 3 samples at clock/6.
// (RL16) ext1 filter uses the same two-bit mode code.
// (RL17) ext0 filter uses the same two-bit mode code.
// (RL18) both config registers at 0xC1; page 0 first, page 1 second.
// (RL19) ext2 pin from 2-bit select in page-1 config bits 5:4.
// (RL20) priority pair {high,low}: 11 highest level down to 00 lowest.
// (RL21) global gate off blocks every request; on, each follows its enable.
// (RL22) filtered input changes only after three equal differing samples.
package eipc_pkg;
  localparam logic [7:0] ADDR_EXT_EN = 8'had;
  localparam logic [7:0] ADDR_EXT_PRIO_LO = 8'hae;
  localparam logic [7:0] ADDR_EXT_PRIO_HI = 8'haf;
  localparam logic [7:0] ADDR_BASIC_PRIO_HI = 8'hb7;
  localparam logic [7:0] ADDR_BASIC_PRIO_LO = 8'hb8;
  localparam logic [7:0] ADDR_EXT2_CTRL = 8'hc0;
  localparam logic [7:0] ADDR_EXT_CFG = 8'hc1;
  localparam logic [3:0] PAGE_CFG0 = 4'h0;
  localparam logic [3:0] PAGE_CFG1 = 4'h1;
  // writable bits; reserved bits are stored and read as zero
  localparam logic [7:0] MASK_BASIC_PRIO = 8'h7f;
  localparam logic [7:0] MASK_EXT = 8'hef;
  localparam logic [7:0] MASK_CFG = 8'hf7;
  localparam logic [7:0] MASK_EXT2_CTRL = 8'h0f;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int BIT_EXT2_POL = 3;
  localparam int BIT_EXT2_EN = 2;
  localparam int BIT_EXT2_FLAG = 1;
  localparam int BIT_EXT2_TYPE = 0;
  localparam int BIT_EN_CMP = 7;
  localparam int BIT_EN_TWI = 6;
  localparam int BIT_EN_KBD = 5;
  localparam int BIT_EN_SYSF = 3;
  localparam int BIT_EN_PCA = 2;
  localparam int BIT_EN_ADC = 1;
  localparam int BIT_EN_SPI = 0;
  localparam int SF_BUS = 7;
  localparam int SF_MCD = 5;
  localparam int SF_RTC = 4;
  localparam int SF_BO1 = 2;
  localparam int SF_BO0 = 1;
  localparam int SF_WDT = 0;
  localparam int CFG0_SEL1_LSB = 6;
  localparam int CFG0_SEL0_LSB = 4;
  localparam int CFG1_SEL1_HI = 7;
  localparam int CFG1_SEL0_HI = 6;
  localparam int CFG1_SEL2_LSB = 4;
  localparam logic [1:0] FLT_OFF = 2'h0;
  localparam logic [1:0] FLT_SYS = 2'h1;
  localparam logic [1:0] FLT_DIV6 = 2'h2;
  localparam logic [2:0] FLT_DIV_LAST = 3'h5;
  localparam logic [1:0] FLT_CNT_LAST = 2'h2;
  localparam int NUM_EXT = 3;
endpackage : eipc_pkg

// ---- eipc_flt_if.sv ----
// link between the block and one input glitch filter
`timescale 1ns/10ps
interface eipc_flt_if;
  logic raw;
  logic [1:0] mode;
  logic filt;
  modport ctrl (output raw, output mode, input filt);
  modport flt (input raw, input mode, output filt);
endinterface : eipc_flt_if

// ---- eipc_filter.sv ----
// three-sample glitch filter for one external interrupt input
`timescale 1ns/10ps
module eipc_filter
  import eipc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  eipc_flt_if.flt bus
);
  typedef struct packed {
    logic [2:0] div;
    logic [1:0] cnt;
    logic out;
  } eipc_flt_state_t;

  eipc_flt_state_t s;
  eipc_flt_state_t next_s;
  logic tick;

  always_comb
  begin
    next_s = s;
    tick = (bus.mode == FLT_SYS) || ((bus.mode == FLT_DIV6) && (s.div == FLT_DIV_LAST));
    if (bus.mode == FLT_DIV6)
    begin
      next_s.div = (s.div == FLT_DIV_LAST) ? 3'h0 : 3'(s.div + 3'h1);
    end
    else
    begin
      next_s.div = 3'h0;
    end
    // off and the reserved code both pass the input straight through
    if ((bus.mode != FLT_SYS) && (bus.mode != FLT_DIV6))
    begin
      next_s.out = bus.raw;
      next_s.cnt = 2'h0;
    end
    else if (tick)
    begin
      if (bus.raw == s.out)
      begin
        next_s.cnt = 2'h0;
      end
      else if (s.cnt == FLT_CNT_LAST)
      begin
        next_s.out = bus.raw; // RL22
        next_s.cnt = 2'h0;
      end
      else
      begin
        next_s.cnt = 2'(s.cnt + 2'h1); // RL22
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '{div: 3'h0, cnt: 2'h0, out: 1'b1};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign bus.filt = s.out;
endmodule : eipc_filter

// ---- eipc_top.sv ----
// external interrupt pin select, filtering, ext2 flag, enables and priorities
`timescale 1ns/10ps
module eipc_top
  import eipc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] ext0_pins,
  input wire logic [7:0] ext1_pins,
  input wire logic [3:0] ext2_pins,
  input wire logic global_irq_gate,
  input wire logic ext2_service_ack,
  input wire logic comparator_flag,
  input wire logic twowire_flag,
  input wire logic keypad_flag,
  input wire logic pca_flag,
  input wire logic adc_done_flag,
  input wire logic spi_done_flag,
  input wire logic missing_clock_flag,
  input wire logic rtc_overflow_flag,
  input wire logic brownout1_flag,
  input wire logic brownout0_flag,
  input wire logic watchdog_overflow_flag,
  input wire logic bus_start_detect_flag,
  input wire logic bus_stop_detect_flag,
  input wire logic uart_tx_flag,
  input wire logic uart_tx_sysflag_en,
  input wire logic [7:0] sysflag_enable_reg,
  output logic ext0_level,
  output logic ext1_level,
  output logic ext2_pending_flag,
  output logic ext2_irq_req,
  output logic comparator_irq_req,
  output logic twowire_irq_req,
  output logic keypad_irq_req,
  output logic sysflag_irq_req,
  output logic pca_irq_req,
  output logic adc_irq_req,
  output logic spi_irq_req,
  output logic [6:0][1:0] basic_prio,
  output logic [7:0][1:0] ext_prio
);
  typedef struct packed {
    logic [7:0] extended_irq_enable;
    logic [7:0] extended_priority_low;
    logic [7:0] extended_priority_high;
    logic [7:0] basic_priority_high;
    logic [7:0] basic_priority_low;
    logic [7:0] ext_irq_config_page0;
    logic [7:0] ext_irq_config_page1;
    logic [7:0] ext2_ctrl;
    logic ext2_active_prev;
    logic [7:0] rdata;
  } eipc_state_t;

  eipc_state_t s;
  eipc_state_t next_s;

  eipc_flt_if flt_bus [NUM_EXT] ();
  logic [NUM_EXT-1:0] chan_raw;
  logic [NUM_EXT-1:0][1:0] chan_mode;
  logic [NUM_EXT-1:0] chan_filt;

  logic [2:0] ext0_pin_select;
  logic [2:0] ext1_pin_select;
  logic [1:0] ext2_pin_select;
  logic ext2_trigger_type;
  logic ext2_polarity_high;
  logic ext2_active;
  logic ext2_hw_set;
  logic sysflag_any;
  logic [7:0] rd_mux;

  assign ext0_pin_select = {s.ext_irq_config_page1[CFG1_SEL0_HI],
                            s.ext_irq_config_page0[CFG0_SEL0_LSB +: 2]}; // RL14
  assign ext1_pin_select = {s.ext_irq_config_page1[CFG1_SEL1_HI],
                            s.ext_irq_config_page0[CFG0_SEL1_LSB +: 2]}; // RL13
  assign ext2_pin_select = s.ext_irq_config_page1[CFG1_SEL2_LSB +: 2]; // RL19

  assign chan_raw[0] = ext0_pins[ext0_pin_select]; // RL14
  assign chan_raw[1] = ext1_pins[ext1_pin_select]; // RL13
  assign chan_raw[2] = ext2_pins[ext2_pin_select]; // RL19

  // filter channel x mode is {page1 bit x, page0 bit x}
  generate
    for (genvar i = 0; i < NUM_EXT; i++)
    begin : g_chan
      assign chan_mode[i] = {s.ext_irq_config_page1[i], s.ext_irq_config_page0[i]}; // RL15 RL16 RL17
      assign flt_bus[i].raw = chan_raw[i];
      assign flt_bus[i].mode = chan_mode[i];
      assign chan_filt[i] = flt_bus[i].filt;
      eipc_filter u_filter (
        .clk(clk),
        .rstn(rstn),
        .bus(flt_bus[i])
      );
    end
  endgenerate

  assign ext0_level = chan_filt[0];
  assign ext1_level = chan_filt[1];

  assign ext2_trigger_type = s.ext2_ctrl[BIT_EXT2_TYPE];
  assign ext2_polarity_high = s.ext2_ctrl[BIT_EXT2_POL];
  assign ext2_active = ext2_polarity_high ? chan_filt[2] : ~chan_filt[2]; // RL3 RL4
  // level mode sets while active, edge mode only on the inactive-to-active change
  assign ext2_hw_set = ext2_trigger_type ? (ext2_active & ~s.ext2_active_prev) // RL4
                                         : ext2_active; // RL3

  always_comb
  begin
    rd_mux = 8'h00;
    case (sfr_addr)
      ADDR_EXT_EN: rd_mux = s.extended_irq_enable;
      ADDR_EXT_PRIO_LO: rd_mux = s.extended_priority_low;
      ADDR_EXT_PRIO_HI: rd_mux = s.extended_priority_high;
      ADDR_BASIC_PRIO_HI: rd_mux = s.basic_priority_high;
      ADDR_BASIC_PRIO_LO: rd_mux = s.basic_priority_low;
      ADDR_EXT2_CTRL: rd_mux = s.ext2_ctrl;
      ADDR_EXT_CFG:
      begin
        if (sfr_page == PAGE_CFG0)
        begin
          rd_mux = s.ext_irq_config_page0; // RL18
        end
        else if (sfr_page == PAGE_CFG1)
        begin
          rd_mux = s.ext_irq_config_page1; // RL18
        end
        else
        begin
          rd_mux = 8'h00;
        end
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    next_s = s;
    next_s.ext2_active_prev = ext2_active;
    if (sfr_rd)
    begin
      next_s.rdata = rd_mux;
    end
    if (sfr_wr)
    begin
      // reserved bits are dropped so they always read back as zero
      case (sfr_addr)
        ADDR_EXT_EN: next_s.extended_irq_enable = sfr_wdata & MASK_EXT; // RL7 RL12
        ADDR_EXT_PRIO_LO: next_s.extended_priority_low = sfr_wdata & MASK_EXT; // RL10
        ADDR_EXT_PRIO_HI: next_s.extended_priority_high = sfr_wdata & MASK_EXT; // RL11
        ADDR_BASIC_PRIO_HI: next_s.basic_priority_high = sfr_wdata & MASK_BASIC_PRIO; // RL6
        ADDR_BASIC_PRIO_LO: next_s.basic_priority_low = sfr_wdata & MASK_BASIC_PRIO; // RL5
        ADDR_EXT2_CTRL: next_s.ext2_ctrl = sfr_wdata & MASK_EXT2_CTRL;
        ADDR_EXT_CFG:
        begin
          if (sfr_page == PAGE_CFG0)
          begin
            next_s.ext_irq_config_page0 = sfr_wdata & MASK_CFG; // RL18
          end
          else if (sfr_page == PAGE_CFG1)
          begin
            next_s.ext_irq_config_page1 = sfr_wdata & MASK_CFG; // RL18
          end
        end
        default: next_s.rdata = next_s.rdata;
      endcase
    end
    // pending flag: service clear, then processor write, hardware set wins last
    if (ext2_service_ack && !(sfr_wr && sfr_addr == ADDR_EXT2_CTRL))
    begin
      next_s.ext2_ctrl[BIT_EXT2_FLAG] = 1'b0; // RL1
    end
    if (ext2_hw_set)
    begin
      next_s.ext2_ctrl[BIT_EXT2_FLAG] = 1'b1; // RL2
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '{extended_irq_enable: RST_REG, extended_priority_low: RST_REG,
             extended_priority_high: RST_REG, basic_priority_high: RST_REG,
             basic_priority_low: RST_REG, ext_irq_config_page0: RST_REG,
             ext_irq_config_page1: RST_REG, ext2_ctrl: RST_REG,
             ext2_active_prev: 1'b0, rdata: 8'h00};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sfr_rdata = s.rdata;
  assign ext2_pending_flag = s.ext2_ctrl[BIT_EXT2_FLAG];

  assign sysflag_any = (missing_clock_flag & sysflag_enable_reg[SF_MCD]) |
                       (rtc_overflow_flag & sysflag_enable_reg[SF_RTC]) |
                       (brownout1_flag & sysflag_enable_reg[SF_BO1]) |
                       (brownout0_flag & sysflag_enable_reg[SF_BO0]) |
                       (watchdog_overflow_flag & sysflag_enable_reg[SF_WDT]) |
                       ((bus_start_detect_flag | bus_stop_detect_flag) &
                        sysflag_enable_reg[SF_BUS]) |
                       (uart_tx_flag & uart_tx_sysflag_en); // RL8

  assign ext2_irq_req = global_irq_gate & s.ext2_ctrl[BIT_EXT2_EN] &
                        s.ext2_ctrl[BIT_EXT2_FLAG]; // RL21
  assign comparator_irq_req = global_irq_gate & s.extended_irq_enable[BIT_EN_CMP] &
                              comparator_flag; // RL21
  assign twowire_irq_req = global_irq_gate & s.extended_irq_enable[BIT_EN_TWI] &
                           twowire_flag; // RL21
  assign keypad_irq_req = global_irq_gate & s.extended_irq_enable[BIT_EN_KBD] &
                          keypad_flag; // RL9
  assign sysflag_irq_req = global_irq_gate & s.extended_irq_enable[BIT_EN_SYSF] &
                           sysflag_any; // RL8
  assign pca_irq_req = global_irq_gate & s.extended_irq_enable[BIT_EN_PCA] & pca_flag; // RL21
  assign adc_irq_req = global_irq_gate & s.extended_irq_enable[BIT_EN_ADC] &
                       adc_done_flag; // RL9
  assign spi_irq_req = global_irq_gate & s.extended_irq_enable[BIT_EN_SPI] &
                       spi_done_flag; // RL9

  // per-source priority code {high,low}; 11 is the highest level
  generate
    for (genvar b = 0; b < 8; b++)
    begin : g_prio
      assign ext_prio[b] = {s.extended_priority_high[b], s.extended_priority_low[b]}; // RL20
      if (b < 7)
      begin : g_basic
        assign basic_prio[b] = {s.basic_priority_high[b], s.basic_priority_low[b]}; // RL20
      end
    end
  endgenerate
endmodule : eipc_top

// ---- eipc_checker.sv ----
// port assertions for the external interrupt and priority block
`timescale 1ns/10ps
module eipc_checker
  import eipc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic global_irq_gate,
  input wire logic ext2_service_ack,
  input wire logic keypad_flag,
  input wire logic spi_done_flag,
  input wire logic comparator_flag,
  input wire logic ext2_pending_flag,
  input wire logic ext2_irq_req,
  input wire logic comparator_irq_req,
  input wire logic keypad_irq_req,
  input wire logic spi_irq_req,
  input wire logic sysflag_irq_req,
  input wire logic [6:0][1:0] basic_prio,
  input wire logic [7:0][1:0] ext_prio
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [6:0] bh, bl;
  logic [7:0] eh;
  wire wr2 = sfr_wr && sfr_addr == ADDR_EXT2_CTRL;
  always_comb
  begin
    for (int i = 0; i < 7; i++) {bh[i], bl[i]} = basic_prio[i];
    for (int i = 0; i < 8; i++) eh[i] = ext_prio[i][1];
  end
  property p_gate;
    !global_irq_gate |-> !(ext2_irq_req || comparator_irq_req || keypad_irq_req
      || spi_irq_req || sysflag_irq_req);
  endproperty
  a_gate: assert property (p_gate) else $error("request with gate off");
  property p_kbd;
    keypad_irq_req |-> keypad_flag && global_irq_gate;
  endproperty
  a_kbd: assert property (p_kbd) else $error("keypad request without flag");
  property p_spi;
    spi_irq_req |-> spi_done_flag;
  endproperty
  a_spi: assert property (p_spi) else $error("spi request without flag");
  property p_cmp;
    comparator_irq_req |-> comparator_flag;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator request without flag");
  property p_set;
    wr2 && sfr_wdata[BIT_EXT2_FLAG] |=> ext2_pending_flag;
  endproperty
  a_set: assert property (p_set) else $error("flag write did not set");
  property p_clr;
    $fell(ext2_pending_flag) |-> $past(ext2_service_ack) || $past(wr2);
  endproperty
  a_clr: assert property (p_clr) else $error("flag cleared without cause");
  property p_bhi;
    sfr_wr && sfr_addr == ADDR_BASIC_PRIO_HI |=> bh == 7'($past(sfr_wdata));
  endproperty
  a_bhi: assert property (p_bhi) else $error("basic high priority mismatch");
  property p_blo;
    sfr_wr && sfr_addr == ADDR_BASIC_PRIO_LO |=> bl == 7'($past(sfr_wdata));
  endproperty
  a_blo: assert property (p_blo) else $error("basic low priority mismatch");
  property p_ehi;
    sfr_wr && sfr_addr == ADDR_EXT_PRIO_HI |=> eh == ($past(sfr_wdata) & MASK_EXT);
  endproperty
  a_ehi: assert property (p_ehi) else $error("extended high priority mismatch");
  property p_res;
    ext_prio[4] == 2'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved priority slot set");
  c_ack: cover property (ext2_service_ack ##1 !ext2_pending_flag);
  c_sys: cover property (sysflag_irq_req);
  c_kbd: cover property (keypad_irq_req);
endmodule : eipc_checker
bind eipc_top eipc_checker i_chk (.*);

// ---- eipc_core.sv ----
// core model that starts ext2 service some cycles after a request
`timescale 1ns/10ps
module eipc_core
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic en,
  input wire logic [3:0] lat,
  output logic ack
);
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      cnt <= 4'h0;
      ack <= 1'b0;
    end
    else
    begin
      ack <= en && req && !ack && cnt == lat;
      cnt <= (en && req && !ack && cnt != lat) ? cnt + 4'h1 : 4'h0;
    end
endmodule : eipc_core

// ---- tb.sv ----
// self-checking bench for the external interrupt and priority block
`timescale 1ns/10ps
module tb;
  import eipc_pkg::*;
  logic clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, rd_d = 0, ack_en = 0, seen;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, ext0_pins = 0, ext1_pins = 0;
  logic [7:0] sysflag_enable_reg = 0, x, f, s = 0, fl = 0, v[6], exp_q[$];
  logic [3:0] sfr_page = 0, ext2_pins = 4'hf, lat = 0;
  logic global_irq_gate = 0, ext2_service_ack, uart_tx_sysflag_en = 0, ext0_level, ext1_level;
  logic comparator_flag, twowire_flag, keypad_flag, pca_flag, adc_done_flag, spi_done_flag;
  logic missing_clock_flag, rtc_overflow_flag, brownout1_flag, brownout0_flag, uart_tx_flag;
  logic watchdog_overflow_flag, bus_start_detect_flag, bus_stop_detect_flag;
  logic ext2_pending_flag, ext2_irq_req, comparator_irq_req, twowire_irq_req, keypad_irq_req;
  logic sysflag_irq_req, pca_irq_req, adc_irq_req, spi_irq_req;
  logic [6:0][1:0] basic_prio;
  logic [7:0][1:0] ext_prio;
  logic [7:0] ad[6] = '{8'had, 8'hae, 8'haf, 8'hb7, 8'hb8, 8'hc1};
  logic [7:0] mk[6] = '{8'hef, 8'hef, 8'hef, 8'h7f, 8'h7f, 8'hf7};
  int failures = 0, checked = 0;
  assign {comparator_flag, twowire_flag, keypad_flag} = fl[7:5];
  assign {pca_flag, adc_done_flag, spi_done_flag} = fl[2:0];
  assign {bus_start_detect_flag, bus_stop_detect_flag, missing_clock_flag, rtc_overflow_flag,
    uart_tx_flag, brownout1_flag, brownout0_flag, watchdog_overflow_flag} = s;
  eipc_top i_dut (.*);
  eipc_core i_core (.clk, .rstn, .req(ext2_irq_req), .en(ack_en), .lat, .ack(ext2_service_ack));
  always #2.5 clk = ~clk;
  task chk(input logic [15:0] g, e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] d);
    {sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {a, pg, d, 1'b1};
    cyc(1);
    sfr_wr = 0;
    cyc(1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] e);
    {sfr_addr, sfr_page, sfr_rd} = {a, pg, 1'b1};
    exp_q.push_back(e);
    cyc(1);
    sfr_rd = 0;
    cyc(1);
  endtask : rd
  function automatic logic [15:0] prio(input logic [7:0] h, l);
    for (int i = 0; i < 8; i++) prio[2*i+:2] = {h[i], l[i]};
  endfunction : prio
  always @(posedge clk) rd_d <= sfr_rd;
  always @(negedge clk) if (rd_d) chk(sfr_rdata, exp_q.pop_front());
  task finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #100000;
    failures++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'h27f3));
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    cyc(1);
    foreach (ad[i]) rd(ad[i], 4'h1, 8'h00);
    rd(8'hc0, 4'h0, 8'h00);
    $display("test reset done");
    foreach (ad[i])
    begin
      v[i] = $urandom & mk[i];
      wr(ad[i], 4'h0, v[i]);
    end
    wr(8'hc1, 4'h1, 8'h37);
    wr(8'h90, 4'h0, 8'hff);
    wr(8'hc1, 4'h5, 8'hff);
    foreach (ad[i]) rd(ad[i], 4'h0, v[i]);
    rd(8'hc1, 4'h1, 8'h37);
    rd(8'h90, 4'h0, 8'h00);
    chk({2'b00, basic_prio}, prio(v[3], v[4]));
    chk(ext_prio, prio(v[2], v[1]));
    $display("test registers done");
    for (int k = 0; k < 8; k++)
    begin
      ext2_pins = 4'hf;
      {ext0_pins, ext1_pins} = 16'($urandom);
      wr(8'hc1, 4'h0, {k[1:0], k[1:0], 4'h0});
      wr(8'hc1, 4'h1, {k[2], k[2], k[1:0], 4'h0});
      wr(8'hc0, 4'h0, 8'h00);
      cyc(3);
      chk({ext1_level, ext0_level, ext2_pending_flag}, {ext1_pins[k], ext0_pins[k], 1'b0});
      ext2_pins[k[1:0]] = 1'b0;
      cyc(3);
      chk(ext2_pending_flag, 1'b1);
    end
    $display("test pin select done");
    for (int k = 0; k < 4; k++)
    begin
      ext2_pins = {4{~k[1]}};
      cyc(2);
      wr(8'hc0, 4'h0, {4'h0, k[1], 2'b10, k[0]});
      cyc(3);
      chk(ext2_pending_flag, 1'b0);
      global_irq_gate = 1;
      ext2_pins = {4{k[1]}};
      cyc(3);
      chk({ext2_pending_flag, ext2_irq_req}, 2'b11);
      lat = 4'($urandom_range(3));
      ack_en = 1;
      cyc(8);
      ack_en = 0;
      cyc(3);
      chk(ext2_pending_flag, !k[0]);
      wr(8'hc0, 4'h0, {4'h0, k[1], 2'b11, k[0]});
      chk(ext2_pending_flag, 1'b1);
      wr(8'hc0, 4'h0, {4'h0, k[1], 2'b10, k[0]});
      chk(ext2_pending_flag, !k[0]);
      global_irq_gate = 0;
    end
    $display("test trigger done");
    repeat (24)
    begin
      x = $urandom & 8'hef;
      wr(8'had, 4'h0, x);
      {global_irq_gate, uart_tx_sysflag_en, fl, s, sysflag_enable_reg} = 26'($urandom);
      cyc(1);
      f = fl;
      f[3] = |(s & sysflag_enable_reg & 8'h37) | (|s[7:6] & sysflag_enable_reg[7])
        | (s[3] & uart_tx_sysflag_en);
      chk({comparator_irq_req, twowire_irq_req, keypad_irq_req, 1'b0, sysflag_irq_req,
        pca_irq_req, adc_irq_req, spi_irq_req}, {8{global_irq_gate}} & x & f);
    end
    $display("test enables done");
    for (int md = 0; md < 4; md++)
    begin
      wr(8'hc1, 4'h0, {5'h00, {3{md[0]}}});
      wr(8'hc1, 4'h1, {5'h00, {3{md[1]}}});
      {ext0_pins, ext1_pins, ext2_pins} = 20'hfffff;
      cyc(40);
      // ext2 in low level mode, flag cleared while its pin idles high
      wr(8'hc0, 4'h0, 8'h00);
      {ext0_pins, ext1_pins, ext2_pins} = 20'h00000;
      seen = 0;
      for (int c = 0; c < 40; c++)
      begin
        if (c == (md == 2 ? 10 : (md == 1 ? 2 : 1)))
        begin
          {ext0_pins, ext1_pins, ext2_pins} = 20'hfffff;
        end
        cyc(1);
        seen = seen | !(ext0_level & ext1_level) | ext2_pending_flag;
      end
      chk(seen, md == 0 || md == 3);
      {ext0_pins, ext1_pins, ext2_pins} = 20'h00000;
      cyc(40);
      chk({ext0_level, ext1_level, ext2_pending_flag}, 3'b001);
    end
    $display("test filter done");
    finish_test();
  end
endmodule : tb
